// >>> hw/sfp_pkg.sv
package sfp_pkg;

  // Register byte offsets.
  localparam logic [11:0] OFF_PTR12     = 12'h000;
  localparam logic [11:0] OFF_PTR13     = 12'h004;
  localparam logic [11:0] OFF_PTR14     = 12'h008;
  localparam logic [11:0] OFF_PTR15     = 12'h00c;
  localparam logic [11:0] OFF_VALID_LO  = 12'h010;
  localparam logic [11:0] OFF_VALID_HI  = 12'h014;
  localparam logic [11:0] OFF_DIR_LO    = 12'h018;
  localparam logic [11:0] OFF_SEL_LO    = 12'h01c;
  localparam logic [11:0] OFF_SEL_HI    = 12'h020;
  localparam logic [11:0] OFF_CTRL      = 12'h024;
  localparam logic [11:0] OFF_WORK_BASE = 12'h028;

  // Field positions.
  localparam int LINE_MSB     = 14;
  localparam int LINE_LSB     = 13;
  localparam int INIT_MSB     = 12;
  localparam int PTR_MSB      = 14;
  localparam int FLAG_MSB     = 15;
  localparam int CTRL_COMBINE = 0;
  localparam int CTRL_STEP_LSB = 8;
  localparam int CTRL_STEP_MSB = 11;

  // Pointers held here are numbers 12 to 15.
  localparam logic [1:0] LOCAL_PTR_TOP = 2'h3;
  localparam int         NUM_LOCAL     = 4;
  localparam int         NUM_ENTRIES   = 16;

  // Values after reset.
  localparam logic [14:0] RST_PTR   = 15'h0000;
  localparam logic [15:0] RST_FLAGS = 16'h0000;
  localparam logic [3:0]  RST_SEL   = 4'h0;
  localparam logic [3:0]  RST_STEP  = 4'h0;
  localparam logic [12:0] RST_WORK  = 13'h0000;

endpackage

// >>> hw/sfp_pointer_program.sv
`timescale 1ns/100ps
module sfp_pointer_program (
  // Clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Pixel program steps.
  input  wire logic        pix_stb,
  input  wire logic [4:0]  pix_entry,
  input  wire logic [3:0]  pix_upper_sel,
  input  wire logic        pix_upper_dir,
  input  wire logic        line_start,
  // Formatted pixel output.
  output logic             out_valid,
  output logic      [12:0] out_addr,
  output logic      [1:0]  out_line,
  output logic      [3:0]  out_ptr,
  output logic             out_local
);

  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a[11:2] == off[11:2]);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    merge = r;
  endfunction

  // Register storage.
  logic [14:0] ptr_reg   [sfp_pkg::NUM_LOCAL];
  logic [14:0] ptr_next  [sfp_pkg::NUM_LOCAL];
  logic [3:0]  sel_reg   [sfp_pkg::NUM_ENTRIES];
  logic [3:0]  sel_next  [sfp_pkg::NUM_ENTRIES];
  logic [15:0] vf_lo_reg;
  logic [15:0] vf_lo_next;
  logic [15:0] vf_hi_reg;
  logic [15:0] vf_hi_next;
  logic [15:0] dir_reg;
  logic [15:0] dir_next;
  logic        combine_reg;
  logic        combine_next;
  logic [3:0]  step_reg;
  logic [3:0]  step_next;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic        pready_reg;
  logic        pready_next;
  logic        pslverr_reg;
  logic        pslverr_next;

  // Pixel path storage.
  logic [12:0] work_reg  [sfp_pkg::NUM_LOCAL];
  logic [12:0] work_next [sfp_pkg::NUM_LOCAL];
  logic        out_valid_reg;
  logic        out_valid_next;
  logic [12:0] out_addr_reg;
  logic [12:0] out_addr_next;
  logic [1:0]  out_line_reg;
  logic [1:0]  out_line_next;
  logic [3:0]  out_ptr_reg;
  logic [3:0]  out_ptr_next;
  logic        out_local_reg;
  logic        out_local_next;

  // Decoded pixel step.
  logic        done;
  logic        mapped;
  logic [3:0]  ptr_wr;
  logic        cur_flag;
  logic        cur_dir;
  logic [3:0]  cur_sel;
  logic        cur_local;
  logic [1:0]  cur_idx;
  logic [12:0] cur_addr;
  logic [1:0]  cur_tag;
  logic        step_en;

  // Access completes at the second access-phase edge.
  assign done = psel && penable && pready_reg;

  always_comb begin
    mapped = 1'b0;
    for (int i = 0; i < sfp_pkg::NUM_LOCAL; i++) begin
      if (hit(paddr, sfp_pkg::OFF_WORK_BASE + 12'(4 * i))) begin
        mapped = 1'b1;
      end
    end
    if (hit(paddr, sfp_pkg::OFF_PTR12) || hit(paddr, sfp_pkg::OFF_PTR13) ||
        hit(paddr, sfp_pkg::OFF_PTR14) || hit(paddr, sfp_pkg::OFF_PTR15) ||
        hit(paddr, sfp_pkg::OFF_VALID_LO) || hit(paddr, sfp_pkg::OFF_VALID_HI) ||
        hit(paddr, sfp_pkg::OFF_DIR_LO) || hit(paddr, sfp_pkg::OFF_SEL_LO) ||
        hit(paddr, sfp_pkg::OFF_SEL_HI) || hit(paddr, sfp_pkg::OFF_CTRL)) begin
      mapped = 1'b1;
    end
  end

  // Register bus next values.
  always_comb begin
    logic [31:0] m;
    logic [31:0] selw;
    m            = 32'h0000_0000;
    selw         = 32'h0000_0000;
    vf_lo_next   = vf_lo_reg;
    vf_hi_next   = vf_hi_reg;
    dir_next     = dir_reg;
    combine_next = combine_reg;
    step_next    = step_reg;
    ptr_wr       = 4'h0;
    for (int i = 0; i < sfp_pkg::NUM_LOCAL; i++) begin
      ptr_next[i] = ptr_reg[i];
    end
    for (int e = 0; e < sfp_pkg::NUM_ENTRIES; e++) begin
      sel_next[e] = sel_reg[e];
    end
    if (done && pwrite) begin
      for (int i = 0; i < sfp_pkg::NUM_LOCAL; i++) begin
        if (hit(paddr, sfp_pkg::OFF_PTR12 + 12'(4 * i))) begin
          m           = merge({17'h00000, ptr_reg[i]}, pwdata, pstrb);
          ptr_next[i] = m[sfp_pkg::PTR_MSB:0];
          ptr_wr[i]   = 1'b1;
        end
      end
      if (hit(paddr, sfp_pkg::OFF_VALID_LO)) begin
        m          = merge({16'h0000, vf_lo_reg}, pwdata, pstrb);
        vf_lo_next = m[sfp_pkg::FLAG_MSB:0];
      end
      if (hit(paddr, sfp_pkg::OFF_VALID_HI)) begin
        m          = merge({16'h0000, vf_hi_reg}, pwdata, pstrb);
        vf_hi_next = m[sfp_pkg::FLAG_MSB:0];
      end
      if (hit(paddr, sfp_pkg::OFF_DIR_LO)) begin
        m        = merge({16'h0000, dir_reg}, pwdata, pstrb);
        dir_next = m[sfp_pkg::FLAG_MSB:0];
      end
      for (int h = 0; h < 2; h++) begin
        if (hit(paddr, sfp_pkg::OFF_SEL_LO + 12'(4 * h))) begin
          for (int k = 0; k < 8; k++) begin
            selw[4*k +: 4] = sel_reg[8*h + k];
          end
          m = merge(selw, pwdata, pstrb);
          for (int k = 0; k < 8; k++) begin
            sel_next[8*h + k] = m[4*k +: 4];
          end
        end
      end
      if (hit(paddr, sfp_pkg::OFF_CTRL)) begin
        m            = merge({20'h00000, step_reg, 7'h00, combine_reg}, pwdata, pstrb);
        combine_next = m[sfp_pkg::CTRL_COMBINE];
        step_next    = m[sfp_pkg::CTRL_STEP_MSB:sfp_pkg::CTRL_STEP_LSB];
      end
    end
  end

  // Read data and completion are prepared one edge ahead of the completing edge.
  always_comb begin
    pready_next  = psel && penable && !pready_reg;
    pslverr_next = pready_next && !mapped;
    prdata_next  = 32'h0000_0000;
    if (pready_next && !pwrite) begin
      for (int i = 0; i < sfp_pkg::NUM_LOCAL; i++) begin
        if (hit(paddr, sfp_pkg::OFF_PTR12 + 12'(4 * i))) begin
          prdata_next = {17'h00000, ptr_reg[i]};
        end
        if (hit(paddr, sfp_pkg::OFF_WORK_BASE + 12'(4 * i))) begin
          prdata_next = {19'h00000, work_reg[i]};
        end
      end
      for (int h = 0; h < 2; h++) begin
        if (hit(paddr, sfp_pkg::OFF_SEL_LO + 12'(4 * h))) begin
          for (int k = 0; k < 8; k++) begin
            prdata_next[4*k +: 4] = sel_reg[8*h + k];
          end
        end
      end
      if (hit(paddr, sfp_pkg::OFF_VALID_LO)) begin
        prdata_next = {16'h0000, vf_lo_reg};
      end
      if (hit(paddr, sfp_pkg::OFF_VALID_HI)) begin
        prdata_next = {16'h0000, vf_hi_reg};
      end
      if (hit(paddr, sfp_pkg::OFF_DIR_LO)) begin
        prdata_next = {16'h0000, dir_reg};
      end
      if (hit(paddr, sfp_pkg::OFF_CTRL)) begin
        prdata_next = {20'h00000, step_reg, 7'h00, combine_reg};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < sfp_pkg::NUM_LOCAL; i++) begin
        ptr_reg[i] <= sfp_pkg::RST_PTR;
      end
      for (int e = 0; e < sfp_pkg::NUM_ENTRIES; e++) begin
        sel_reg[e] <= sfp_pkg::RST_SEL;
      end
      vf_lo_reg   <= sfp_pkg::RST_FLAGS;
      vf_hi_reg   <= sfp_pkg::RST_FLAGS;
      dir_reg     <= sfp_pkg::RST_FLAGS;
      combine_reg <= 1'b0;
      step_reg    <= sfp_pkg::RST_STEP;
      prdata_reg  <= 32'h0000_0000;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      ptr_reg     <= ptr_next;
      sel_reg     <= sel_next;
      vf_lo_reg   <= vf_lo_next;
      vf_hi_reg   <= vf_hi_next;
      dir_reg     <= dir_next;
      combine_reg <= combine_next;
      step_reg    <= step_next;
      prdata_reg  <= prdata_next;
      pready_reg  <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  // Decode the current program entry.
  always_comb begin
    cur_flag  = pix_entry[4] ? vf_hi_reg[pix_entry[3:0]] : vf_lo_reg[pix_entry[3:0]];
    cur_dir   = pix_entry[4] ? pix_upper_dir : dir_reg[pix_entry[3:0]];
    cur_sel   = pix_entry[4] ? pix_upper_sel : sel_reg[pix_entry[3:0]];
    cur_local = (cur_sel[3:2] == sfp_pkg::LOCAL_PTR_TOP);
    cur_idx   = cur_sel[1:0];
    cur_addr  = work_reg[cur_idx];
    cur_tag   = ptr_reg[cur_idx][sfp_pkg::LINE_MSB:sfp_pkg::LINE_LSB];
    step_en   = pix_stb && cur_flag && cur_local;
  end

  // Pixel path next values; a reload wins over a step.
  always_comb begin
    out_valid_next = pix_stb && cur_flag;
    out_ptr_next   = cur_sel;
    out_local_next = cur_local;
    out_addr_next  = cur_local ? cur_addr : 13'h0000;
    out_line_next  = (cur_local && !combine_reg) ? cur_tag : 2'h0;
    for (int i = 0; i < sfp_pkg::NUM_LOCAL; i++) begin
      work_next[i] = work_reg[i];
      if (line_start || ptr_wr[i]) begin
        work_next[i] = ptr_next[i][sfp_pkg::INIT_MSB:0];
      end else if (step_en && (cur_idx == 2'(i))) begin
        if (cur_dir) begin
          work_next[i] = work_reg[i] - 13'(step_reg);
        end else begin
          work_next[i] = work_reg[i] + 13'(step_reg);
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < sfp_pkg::NUM_LOCAL; i++) begin
        work_reg[i] <= sfp_pkg::RST_WORK;
      end
      out_valid_reg <= 1'b0;
      out_addr_reg  <= 13'h0000;
      out_line_reg  <= 2'h0;
      out_ptr_reg   <= 4'h0;
      out_local_reg <= 1'b0;
    end else begin
      work_reg      <= work_next;
      out_valid_reg <= out_valid_next;
      out_addr_reg  <= out_addr_next;
      out_line_reg  <= out_line_next;
      out_ptr_reg   <= out_ptr_next;
      out_local_reg <= out_local_next;
    end
  end

  assign prdata    = prdata_reg;
  assign pready    = pready_reg;
  assign pslverr   = pslverr_reg;
  assign out_valid = out_valid_reg;
  assign out_addr  = out_addr_reg;
  assign out_line  = out_line_reg;
  assign out_ptr   = out_ptr_reg;
  assign out_local = out_local_reg;

  // Checks.
  logic first_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_reg <= 1'b1;
    end else begin
      first_reg <= 1'b0;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  pixel_drop_a: assert property ((pix_stb && !cur_flag) |=> !out_valid)
    else $error("Skipped entry produced a valid pixel.");
  pixel_keep_a: assert property ((pix_stb && cur_flag) |=> out_valid)
    else $error("Valid entry produced no pixel.");
  step_up_a: assert property ((step_en && !cur_dir && !line_start && ptr_wr == 4'h0)
      |=> work_reg[$past(cur_idx)] == 13'($past(cur_addr) + 13'($past(step_reg))))
    else $error("Pointer did not advance by the step.");
  step_down_a: assert property ((step_en && cur_dir && !line_start && ptr_wr == 4'h0)
      |=> work_reg[$past(cur_idx)] == 13'($past(cur_addr) - 13'($past(step_reg))))
    else $error("Pointer did not retreat by the step.");
  line_tag_a: assert property ((pix_stb && cur_local && !combine_reg)
      |=> out_line == $past(cur_tag) && out_addr == $past(cur_addr))
    else $error("Output line tag does not follow the pointer.");
  combine_line_a: assert property ((pix_stb && combine_reg) |=> out_line == 2'h0)
    else $error("Line tag used while combining lines.");
  reload_init_a: assert property (line_start
      |=> work_reg[3] == $past(ptr_next[3][12:0]) && work_reg[0] == $past(ptr_next[0][12:0]))
    else $error("Line start did not reload the initial address.");
  flag_write_a: assert property ((done && pwrite && hit(paddr, sfp_pkg::OFF_VALID_HI)
      && pstrb[1:0] == 2'h3) |=> vf_hi_reg == $past(pwdata[15:0]))
    else $error("High valid flags not written.");
  dir_write_a: assert property ((done && pwrite && hit(paddr, sfp_pkg::OFF_DIR_LO)
      && pstrb[1:0] == 2'h3) |=> dir_reg == $past(pwdata[15:0]))
    else $error("Direction bits not written.");
  ptr_select_a: assert property (pix_stb |=> out_ptr == $past(cur_sel))
    else $error("Output pointer differs from the entry selector.");
  reset_zero_a: assert property (first_reg |-> vf_lo_reg == 16'h0000
      && dir_reg == 16'h0000 && step_reg == 4'h0 && !out_valid)
    else $error("Field not zero after reset.");

endmodule

// >>> test/sfp_pix_source.sv
`timescale 1ns/100ps
module sfp_pix_source (
  // Clock.
  input  wire logic       pclk,
  // Program steps towards the block.
  output logic            pix_stb,
  output logic      [4:0] pix_entry,
  output logic      [3:0] pix_upper_sel,
  output logic            pix_upper_dir,
  output logic            line_start
);
  initial begin
    pix_stb       = 1'b0;
    pix_entry     = 5'h00;
    pix_upper_sel = 4'h0;
    pix_upper_dir = 1'b0;
    line_start    = 1'b0;
  end

  // One program step, or one line reload when ld is set.
  task automatic send(input logic [4:0] e, input logic [3:0] s, input logic d, input logic ld);
    @(posedge pclk);
    pix_stb       <= ~ld;
    line_start    <= ld;
    pix_entry     <= e;
    pix_upper_sel <= s;
    pix_upper_dir <= d;
    @(posedge pclk);
    pix_stb       <= 1'b0;
    line_start    <= 1'b0;
    pix_entry     <= ~e;
    pix_upper_sel <= ~s;
    pix_upper_dir <= ~d;
  endtask
endmodule

// >>> test/tb.sv
`timescale 1ns/100ps
module tb;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        pix_stb;
  logic [4:0]  pix_entry;
  logic [3:0]  pix_upper_sel;
  logic        pix_upper_dir;
  logic        line_start;
  logic        out_valid;
  logic [12:0] out_addr;
  logic [1:0]  out_line;
  logic [3:0]  out_ptr;
  logic        out_local;
  int          n_mismatch;
  int          n_tests;
  int          seed;
  int          k;
  logic [31:0] rd;
  logic        er;
  logic [31:0] d;
  logic [12:0] init_m [4];
  logic [1:0]  line_m [4];
  logic [12:0] work_m [4];
  logic [31:0] flags_m;
  logic [15:0] dir_m;
  logic [63:0] sel_m;
  logic [3:0]  step_m;
  logic        comb_m;

  sfp_pointer_program dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pix_stb(pix_stb), .pix_entry(pix_entry),
    .pix_upper_sel(pix_upper_sel), .pix_upper_dir(pix_upper_dir), .line_start(line_start),
    .out_valid(out_valid), .out_addr(out_addr), .out_line(out_line), .out_ptr(out_ptr),
    .out_local(out_local));

  sfp_pix_source src (.pclk(pclk), .pix_stb(pix_stb), .pix_entry(pix_entry),
    .pix_upper_sel(pix_upper_sel), .pix_upper_dir(pix_upper_dir), .line_start(line_start));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
                     input logic [3:0] s);
    int i;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    pstrb   <= s;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (i == 20) begin
      n_mismatch++;
      complete_run();
    end
  endtask

  // Writes a register, reads it back and compares with the expected image.
  task automatic wr_rd(input logic [11:0] a, input logic [31:0] wd, input logic [31:0] exp);
    apb(1'b1, a, wd, 4'hf);
    apb(1'b0, a, 32'h0, 4'hf);
    check(rd, exp);
  endtask

  function automatic logic [3:0] sel_of(input logic [4:0] e, input logic [3:0] us);
    return (e < 5'h10) ? sel_m[{e[3:0], 2'h0} +: 4] : us;
  endfunction

  task automatic do_step(input logic [4:0] e, input logic [3:0] us, input logic ud);
    logic [3:0] p;
    logic       f;
    logic       dn;
    p  = sel_of(e, us);
    f  = flags_m[e];
    dn = (e < 5'h10) ? dir_m[e[3:0]] : ud;
    src.send(e, us, ud, 1'b0);
    @(negedge pclk);
    check(out_valid, f);
    check(out_ptr, p);
    check(out_local, &p[3:2]);
    if (&p[3:2]) begin
      check(out_addr, work_m[p[1:0]]);
      check(out_line, comb_m ? 2'h0 : line_m[p[1:0]]);
      if (f) work_m[p[1:0]] = dn ? work_m[p[1:0]] - step_m : work_m[p[1:0]] + step_m;
    end
  endtask

  initial begin
    seed = 42898;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'h0;
    n_mismatch = 0;
    n_tests = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    for (k = 0; k < 14; k++) begin
      apb(1'b0, 12'(4 * k), 32'h0, 4'hf);
      check(rd, 32'h0);
    end
    apb(1'b0, 12'h038, 32'h0, 4'hf);
    check({31'h0, er}, 32'h1);
    check(rd, 32'h0);
    // Initial addresses stay inside an 8192-wide output line.
    for (k = 0; k < 4; k++) begin
      d = $random(seed);
      init_m[k] = d[12:0];
      line_m[k] = d[14:13];
      work_m[k] = d[12:0];
      wr_rd(12'(4 * k), d & 32'h0000_7fff, {17'h0, d[14:0]});
    end
    d = $random(seed);
    flags_m[15:0] = d[15:0];
    wr_rd(12'h010, d & 32'h0000_ffff, {16'h0, d[15:0]});
    apb(1'b1, 12'h010, 32'h0000_ff00, 4'h2);
    flags_m[15:8] = 8'hff;
    d = $random(seed);
    flags_m[31:16] = d[15:0];
    wr_rd(12'h014, d & 32'h0000_ffff, {16'h0, d[15:0]});
    d = $random(seed);
    dir_m = d[15:0];
    wr_rd(12'h018, d & 32'h0000_ffff, {16'h0, d[15:0]});
    sel_m = {$random(seed), $random(seed)} | 64'h0c0c0c0c0c0c0c0c;
    apb(1'b1, 12'h01c, sel_m[31:0], 4'hf);
    apb(1'b1, 12'h020, sel_m[63:32], 4'hf);
    apb(1'b1, 12'h028, 32'h0000_1fff, 4'hf);
    step_m = 4'h5;
    comb_m = 1'b0;
    apb(1'b1, 12'h024, 32'h00000500, 4'hf);
    for (k = 0; k < 80; k++) begin
      if (k == 40) begin
        comb_m = 1'b1;
        step_m = 4'hf;
        apb(1'b1, 12'h024, 32'h00000f01, 4'hf);
      end
      if (k == 60) begin
        src.send(5'h00, 4'h0, 1'b0, 1'b1);
        work_m = init_m;
      end
      d = $random(seed);
      do_step(d[4:0], d[11:8], d[12]);
    end
    for (k = 0; k < 4; k++) begin
      apb(1'b0, 12'(40 + 4 * k), 32'h0, 4'hf);
      check(rd, {19'h0, work_m[k]});
    end
    complete_run();
  end
endmodule
